/* logic/timer8_pkg.sv */
// Operation
// - mode select 3 or 7 runs fast PWM, single up slope.
// - fast PWM top is 0xFF for mode 3, compare A for 7.
// - fast PWM changes output on match, opposite change at TOP to BOTTOM.
// - fast PWM counts up to TOP, then clears on next tick.
// - fast PWM sets wrap flag whenever counter reaches TOP.
// - compare mode two gives non-inverted PWM, three inverted.
// - channel A mode one with high mode bit toggles on match; B never.
// - output state reaches the pin only when pin direction is output.
// - fixed-top fast period 256 ticks; tick divides clock by 1..1024.
// - fast compare A BOTTOM gives spike, MAX gives constant level.
// - fast compares double buffered; toggle with compare A zero gives half-clock square wave.
// - mode 1 or 5 runs phase-correct, top 0xFF or compare A.
// - phase-correct clears on up match, sets on down match; inverted reverse.
// - phase-correct reverses at TOP, holding TOP for one tick.
// - phase-correct sets wrap flag when counter reaches BOTTOM.
// - fixed-top phase-correct period is 510 ticks.
// - phase-correct BOTTOM compare gives constant low, MAX constant high.
// - leaving MAX forces up-match result at period start.
// - a missed up-counting match still applies its output change.
// - fully synchronous; tick is only a clock enable.
// - compare mode zero leaves output state alone, pin under port.
// - counter is 8 bits, MAX 0xFF, BOTTOM 0x00.
package timer8_pkg;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  // mode select values
  localparam logic [2:0] MODE_PC_FIX = 3'h1;
  localparam logic [2:0] MODE_FAST_FIX = 3'h3;
  localparam logic [2:0] MODE_PC_VAR = 3'h5;
  localparam logic [2:0] MODE_FAST_VAR = 3'h7;
  // compare output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // prescale selects and divider masks
  localparam int unsigned PRE_W = 10;
  localparam logic [2:0] PRE_STOP = 3'h0;
  localparam logic [2:0] PRE_1 = 3'h1;
  localparam logic [2:0] PRE_8 = 3'h2;
  localparam logic [2:0] PRE_64 = 3'h3;
  localparam logic [2:0] PRE_256 = 3'h4;
  localparam logic [2:0] PRE_1024 = 3'h5;
  localparam logic [9:0] MASK_1 = 10'h000;
  localparam logic [9:0] MASK_8 = 10'h007;
  localparam logic [9:0] MASK_64 = 10'h03F;
  localparam logic [9:0] MASK_256 = 10'h0FF;
  localparam logic [9:0] MASK_1024 = 10'h3FF;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMPA = 8'h04;
  localparam logic [7:0] OFF_CMPB = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PORT = 8'h14;
  localparam int unsigned ST_WRAP = 0;
  localparam int unsigned ST_DIR = 1;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [3:0] PORT_RESET = 4'h0;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_type;

  typedef struct packed {
    logic [2:0] prescale_sel;
    logic [1:0] compare_out_mode_a;
    logic [1:0] compare_out_mode_b;
    logic [2:0] waveform_mode_sel;
  } ctrl_type;

  typedef struct packed {
    logic port_b;
    logic port_a;
    logic dir_b;
    logic dir_a;
  } port_type;
endpackage : timer8_pkg

/* logic/timer8_pwm_modes.sv */
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module timer8_pwm_modes
  import timer8_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // overflow flag
  input wire logic wrap_ack,
  output logic wrap_flag,
  // waveform state
  output logic [CNT_W-1:0] count_value,
  output logic match_output_a,
  output logic match_output_b,
  // port pins
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [9:0] pre_mask(input logic [2:0] sel);
    logic [9:0] m;
    case (sel)
      PRE_1: m = MASK_1;
      PRE_8: m = MASK_8;
      PRE_64: m = MASK_64;
      PRE_256: m = MASK_256;
      default: m = MASK_1024;
    endcase
    return m;
  endfunction : pre_mask

  // next internal output state for one channel on a timer tick
  function automatic logic oc_next(
    input logic oc,
    input logic [1:0] com,
    input logic tog_ok,
    input logic fast,
    input logic [7:0] cnt,
    input logic [7:0] ocr,
    input logic [7:0] top,
    input logic up,
    input logic sym
  );
    logic r;
    logic up_res;
    logic hit;
    r = oc;
    up_res = (com == COM_SET);
    hit = (cnt == ocr);
    // mode zero leaves the state alone
    if (com == COM_TOGGLE)
    begin
      if (tog_ok && hit)
        r = ~oc;
    end
    else if (com[1])
    begin
      if (fast)
      begin
        // opposite change at TOP; match at TOP ignored
        // BOTTOM gives spike, MAX constant level
        if (cnt == top)
          r = ~up_res;
        else if (hit)
          r = up_res;
      end
      else
      begin
        // leaving MAX forces up result at period start
        if (sym)
          r = up_res;
        // BOTTOM seen as up, TOP as down
        else if (hit)
          r = up ? up_res : ~up_res;
        else if (up && cnt > ocr)
          r = up_res;
      end
    end
    return r;
  endfunction : oc_next

  // ----------------------------------------
  // registers
  // ----------------------------------------
  ctrl_type ctrl_q, ctrl_d;
  port_type port_q, port_d;
  logic [31:0] prdata_q, prdata_d;
  logic wrap_q, wrap_d;
  logic [9:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;
  dir_type dir_q, dir_d;
  logic [7:0] buf_q [2];
  logic [7:0] act_q [2];
  logic oc_q [2];
  logic lmax_q [2];

  logic wr_en;
  logic rd_setup;
  logic addr_hit;
  logic tick;
  logic mode_fast;
  logic mode_pc;
  logic mode_pwm;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic up_eff;
  logic wrap_set;
  logic [2:0] mode;

  assign mode = ctrl_q.waveform_mode_sel;
  assign mode_fast = (mode == MODE_FAST_FIX) || (mode == MODE_FAST_VAR);
  assign mode_pc = (mode == MODE_PC_FIX) || (mode == MODE_PC_VAR);
  assign mode_pwm = mode_fast || mode_pc;
  // top select, fixed or compare A
  assign top = mode[2] ? act_q[0] : CNT_MAX;
  assign at_top = (cnt_q >= top);
  assign at_bottom = (cnt_q == CNT_BOTTOM);
  assign up_eff = at_bottom ? 1'b1 :
                  (at_top ? 1'b0 : (dir_q == DIR_UP));

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign addr_hit = (paddr == OFF_CTRL) || (paddr == OFF_CMPA) ||
                    (paddr == OFF_CMPB) || (paddr == OFF_COUNT) ||
                    (paddr == OFF_STATUS) || (paddr == OFF_PORT);
  // zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_q;

  always_comb
  begin
    ctrl_d = ctrl_q;
    port_d = port_q;
    prdata_d = prdata_q;
    if (wr_en && paddr == OFF_CTRL)
      ctrl_d = ctrl_type'(pwdata[9:0]);
    if (wr_en && paddr == OFF_PORT)
      port_d = port_type'(pwdata[3:0]);
    // read data latched in setup so it comes from flops
    if (rd_setup)
    begin
      case (paddr)
        OFF_CTRL: prdata_d = {22'h000000, ctrl_q};
        OFF_CMPA: prdata_d = {24'h000000, buf_q[0]};
        OFF_CMPB: prdata_d = {24'h000000, buf_q[1]};
        OFF_COUNT: prdata_d = {24'h000000, cnt_q};
        OFF_STATUS: prdata_d = {30'h00000000, dir_q, wrap_q};
        OFF_PORT: prdata_d = {28'h0000000, port_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= ctrl_type'(CTRL_RESET);
      port_q <= port_type'(PORT_RESET);
      prdata_q <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      port_q <= port_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // tick is the clock divided by 1, 8, 64, 256 or 1024
  // tick is only an enable, no derived clock
  assign pre_d = pre_q + 10'h001;
  assign tick = (ctrl_q.prescale_sel != PRE_STOP) &&
                (ctrl_q.prescale_sel <= PRE_1024) &&
                ((pre_q & pre_mask(ctrl_q.prescale_sel)) ==
                 pre_mask(ctrl_q.prescale_sel));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_q <= 10'h000;
    else
      pre_q <= pre_d;
  end

  // ----------------------------------------
  // counter, direction, wrap flag
  // ----------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    wrap_set = 1'b0;
    if (tick && mode_fast)
    begin
      dir_d = DIR_UP;
      // count up to TOP, then clear
      // a count above TOP also clears to BOTTOM, no 8-bit wrap at MAX
      if (at_top)
        cnt_d = CNT_BOTTOM;
      else
        cnt_d = cnt_q + CNT_ONE;
      wrap_set = at_top;
    end
    else if (tick && mode_pc)
    begin
      // turn at TOP after one tick there
      // 255 up plus 255 down gives 510 ticks
      if (dir_q == DIR_UP)
      begin
        if (at_top)
        begin
          dir_d = DIR_DOWN;
          cnt_d = at_bottom ? CNT_BOTTOM : cnt_q - CNT_ONE;
        end
        else
          cnt_d = cnt_q + CNT_ONE;
      end
      else if (at_bottom)
      begin
        dir_d = DIR_UP;
        cnt_d = at_top ? CNT_BOTTOM : cnt_q + CNT_ONE;
      end
      else
        cnt_d = cnt_q - CNT_ONE;
      wrap_set = (dir_q == DIR_DOWN) && (cnt_d == CNT_BOTTOM);
    end
    if (wr_en && paddr == OFF_COUNT)
      cnt_d = pwdata[7:0];
    // sticky until ack or write of one; a set wins
    wrap_d = wrap_q;
    if (wrap_ack || (wr_en && paddr == OFF_STATUS && pwdata[ST_WRAP]))
      wrap_d = 1'b0;
    if (wrap_set)
      wrap_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= CNT_BOTTOM;
      dir_q <= DIR_UP;
      wrap_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      wrap_q <= wrap_d;
    end
  end

  // ----------------------------------------
  // compare channels, 0 is A, 1 is B
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic [7:0] buf_d;
      logic [7:0] act_d;
      logic oc_d;
      logic lmax_d;
      logic [1:0] com;
      logic tog_ok;
      logic [7:0] wr_off;
      assign com = (ch == 0) ? ctrl_q.compare_out_mode_a :
                               ctrl_q.compare_out_mode_b;
      // toggle needs the high mode bit and channel A
      assign tog_ok = (ch == 0) && mode[2];
      assign wr_off = (ch == 0) ? OFF_CMPA : OFF_CMPB;

      always_comb
      begin
        buf_d = buf_q[ch];
        act_d = act_q[ch];
        oc_d = oc_q[ch];
        lmax_d = lmax_q[ch];
        if (wr_en && paddr == wr_off)
          buf_d = pwdata[7:0];
        if (!mode_pwm)
          act_d = buf_q[ch];
        else if (tick)
        begin
          oc_d = oc_next(oc_q[ch], com, tog_ok, mode_fast, cnt_q,
                         act_q[ch], top, up_eff,
                         lmax_q[ch] && at_bottom);
          if (at_bottom)
            lmax_d = 1'b0;
          // double buffered compare in PWM modes
          if (at_top)
          begin
            act_d = buf_q[ch];
            lmax_d = mode_pc && (act_q[ch] == CNT_MAX) &&
                     (buf_q[ch] != CNT_MAX);
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          buf_q[ch] <= CNT_BOTTOM;
          act_q[ch] <= CNT_BOTTOM;
          oc_q[ch] <= 1'b0;
          lmax_q[ch] <= 1'b0;
        end
        else
        begin
          buf_q[ch] <= buf_d;
          act_q[ch] <= act_d;
          oc_q[ch] <= oc_d;
          lmax_q[ch] <= lmax_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // pin override
  // ----------------------------------------
  logic conn_a;
  logic conn_b;
  // mode zero, or a reserved one, keeps the port value
  assign conn_a = ctrl_q.compare_out_mode_a[1] ||
                  (ctrl_q.compare_out_mode_a == COM_TOGGLE && mode[2]);
  assign conn_b = ctrl_q.compare_out_mode_b[1];

  // pin driven only when its direction is output
  assign pin_a_oe = port_q.dir_a;
  assign pin_b_oe = port_q.dir_b;
  assign pin_a_out = port_q.dir_a &&
                     (conn_a ? oc_q[0] : port_q.port_a);
  assign pin_b_out = port_q.dir_b &&
                     (conn_b ? oc_q[1] : port_q.port_b);

  assign wrap_flag = wrap_q;
  assign count_value = cnt_q;
  assign match_output_a = oc_q[0];
  assign match_output_b = oc_q[1];

endmodule : timer8_pwm_modes
`default_nettype wire

/* verif/timer8_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module timer8_monitor
  import timer8_pkg::*;
(
  // bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // timer and pins
  input wire logic wrap_ack,
  input wire logic wrap_flag,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe
);
  logic wr;
  assign wr = psel && penable && pwrite;
  default clocking mck @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // checks
  // ----
  pin_a_gate_a: assert property (!pin_a_oe |-> !pin_a_out)
    else $error("pin a gating");
  pin_b_gate_a: assert property (!pin_b_oe |-> !pin_b_out)
    else $error("pin b gating");
  dir_a_src_a: assert property ($changed(pin_a_oe) |->
    $past(wr) && $past(paddr) == OFF_PORT)
    else $error("pin a direction");
  dir_b_src_a: assert property ($changed(pin_b_oe) |->
    $past(wr) && $past(paddr) == OFF_PORT)
    else $error("pin b direction");
  count_step_a: assert property ($changed(count_value) && !$past(wr) |->
    count_value == $past(count_value) + 8'h01 ||
    count_value == $past(count_value) - 8'h01 ||
    count_value == CNT_BOTTOM)
    else $error("counter jump");
  // flag may trail the wrap by one edge
  wrap_set_a: assert property ($changed(count_value) && !$past(wr) &&
    count_value == CNT_BOTTOM |-> ##[0:1] wrap_flag)
    else $error("flag not set");
  wrap_hold_a: assert property (wrap_flag && !wrap_ack && !wr |=> wrap_flag)
    else $error("flag dropped");
  wrap_clear_a: assert property (wrap_ack |=> !wrap_flag ||
    count_value == CNT_BOTTOM)
    else $error("flag not cleared");
  wrap_c: cover property ($rose(wrap_flag));
  drive_c: cover property (pin_a_oe && pin_a_out);
  top_c: cover property (count_value == CNT_MAX ##1 count_value == 8'hFE);
endmodule : timer8_monitor

bind timer8_pwm_modes timer8_monitor u_timer8_monitor (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .wrap_ack, .wrap_flag, .count_value,
  .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe);
`default_nettype wire

/* verif/pin_load.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_load (
  // pin from the timer
  input wire logic drive,
  input wire logic drive_en,
  // line at the load
  output logic level
);
  // pull-down: an undriven line must never read high
  assign level = drive_en ? drive : 1'b0;
endmodule : pin_load
`default_nettype wire

/* verif/timer8_pwm_modes_test.sv */
`timescale 1ns/10ps
`default_nettype none
module timer8_pwm_modes_test
  import timer8_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, wrap_ack, pready, pslverr;
  logic wrap_flag, match_output_a, match_output_b, lvl_a, lvl_b, err;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  logic [7:0] paddr, count_value;
  logic [31:0] pwdata, prdata, rdat;
  int fail_count = 0;
  int comparisons = 0;

  timer8_pwm_modes u_timer8_pwm_modes (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wrap_ack,
    .wrap_flag, .count_value, .match_output_a, .match_output_b,
    .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe);
  pin_load u_pin_load_a (.drive(pin_a_out), .drive_en(pin_a_oe),
    .level(lvl_a));
  pin_load u_pin_load_b (.drive(pin_b_out), .drive_en(pin_b_oe),
    .level(lvl_b));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // ----
  // bus access
  // ----
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (pready !== 1'b1)
    begin
      fail_count++;
      test_done();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // stop in a frozen mode so every run starts from count zero
  task automatic setup(input logic [2:0] md, input logic [1:0] ca,
    input logic [1:0] cb, input logic [2:0] pre, input logic [7:0] cv,
    input logic [3:0] port);
    ctrl_type c;
    c = '{pre, ca, cb, md};
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_COUNT, 32'h0);
    apb(1'b1, OFF_CMPA, {24'h0, cv});
    apb(1'b1, OFF_CMPB, 32'h80);
    apb(1'b1, OFF_PORT, {28'h0, port});
    apb(1'b1, OFF_CTRL, {22'h0, c});
  endtask : setup

  task automatic run(input int n, input int ea, input int eb, input int ez,
    input int et);
    int ha = 0, hb = 0, nz = 0, nt = 0;
    repeat (n) @(posedge pclk);
    repeat (n)
    begin
      // sample mid-cycle, away from the edge that updates the outputs
      @(negedge pclk);
      ha += int'(lvl_a === 1'b1);
      hb += int'(lvl_b === 1'b1);
      nz += int'(count_value === CNT_BOTTOM);
      nt += int'(count_value === CNT_MAX);
    end
    if (ea >= 0)
      chk("pin a highs", ea, ha);
    if (eb >= 0)
      chk("pin b highs", eb, hb);
    chk("bottom cycles", ez, nz);
    chk("top cycles", et, nt);
    @(posedge pclk);
  endtask : run

  task automatic wait_flag;
    int i;
    for (i = 0; i < 600 && wrap_flag !== 1'b1; i++)
      @(posedge pclk);
    if (wrap_flag !== 1'b1)
    begin
      fail_count++;
      test_done();
    end
  endtask : wait_flag

  task automatic wait_count(input logic [7:0] v);
    int i;
    for (i = 0; i < 600 && count_value !== v; i++)
      @(negedge pclk);
    if (count_value !== v)
    begin
      fail_count++;
      test_done();
    end
    @(posedge pclk);
  endtask : wait_count

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wrap_ack = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("count at reset", 32'h0, rdat);
    apb(1'b0, OFF_PORT, 32'h0);
    chk("port at reset", 32'h0, rdat);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    setup(MODE_FAST_FIX, COM_CLEAR, COM_SET, PRE_1, 8'h40, 4'h3);
    run(256, 65, 127, 1, 1);
    setup(MODE_FAST_FIX, COM_CLEAR, COM_SET, PRE_8, 8'h40, 4'h3);
    run(2048, 520, 1016, 8, 8);
    setup(MODE_FAST_FIX, COM_CLEAR, COM_OFF, PRE_1, 8'h00, 4'h3);
    run(256, 1, 0, 1, 1);
    setup(MODE_FAST_FIX, COM_CLEAR, COM_OFF, PRE_1, 8'hFF, 4'h3);
    run(256, 256, 0, 1, 1);
    setup(MODE_FAST_VAR, COM_TOGGLE, COM_TOGGLE, PRE_1, 8'h00, 4'hB);
    run(256, 128, 256, 256, 0);
    setup(MODE_FAST_VAR, COM_CLEAR, COM_OFF, PRE_1, 8'h80, 4'h3);
    run(129, 129, 0, 1, 0);
    setup(MODE_PC_FIX, COM_CLEAR, COM_CLEAR, PRE_1, 8'h40, 4'h3);
    run(510, 128, 256, 1, 1);
    setup(MODE_PC_FIX, COM_SET, COM_CLEAR, PRE_1, 8'h40, 4'h3);
    run(510, 382, 256, 1, 1);
    setup(MODE_PC_FIX, COM_CLEAR, COM_OFF, PRE_1, 8'h00, 4'h3);
    run(510, 0, 0, 1, 1);
    setup(MODE_PC_FIX, COM_SET, COM_OFF, PRE_1, 8'h00, 4'h3);
    run(510, 510, 0, 1, 1);
    setup(MODE_PC_VAR, COM_CLEAR, COM_OFF, PRE_1, 8'h80, 4'h3);
    run(256, 256, 0, 1, 0);
    setup(MODE_PC_FIX, COM_CLEAR, COM_OFF, PRE_1, 8'hFF, 4'h3);
    run(510, 510, 0, 1, 1);
    setup(MODE_PC_FIX, COM_CLEAR, COM_OFF, PRE_1, 8'hFF, 4'h2);
    run(510, 0, 0, 1, 1);
    // leave MAX while running: next bottom must force the up-match level
    apb(1'b1, OFF_CMPA, 32'h40);
    apb(1'b0, OFF_CMPA, 32'h0);
    chk("compare a buffer", 32'h40, rdat);
    wait_count(CNT_MAX);
    wait_count(CNT_BOTTOM);
    wait_count(8'h10);
    chk("output a after max", 32'h0, {31'h0, match_output_a});
    wait_flag();
    repeat (5) @(posedge pclk);
    chk("flag held", 32'h1, {31'h0, wrap_flag});
    apb(1'b1, OFF_STATUS, 32'h1);
    chk("flag after write", 32'h0, {31'h0, wrap_flag});
    wait_flag();
    wrap_ack <= 1'b1;
    @(posedge pclk);
    wrap_ack <= 1'b0;
    @(posedge pclk);
    chk("flag after ack", 32'h0, {31'h0, wrap_flag});
    test_done();
  end
endmodule : timer8_pwm_modes_test
`default_nettype wire
